// *** shared/hbd_pkg.sv ***
package hbd_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] HBD_ADDR_DET_A   = 8'h0d;
   localparam logic [7:0] HBD_ADDR_DET_B   = 8'h0e;
   localparam logic [7:0] HBD_ADDR_GAIN_L  = 8'h0f;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int HBD_A_EN_BIT       = 7;
   localparam int HBD_A_TYPE_LSB     = 5;
   localparam int HBD_A_JACK_DB_LSB  = 2;
   localparam int HBD_A_BTN_DB_LSB   = 0;
   localparam int HBD_B_COUPLE_BIT   = 7;
   localparam int HBD_B_CFG_A_BIT    = 6;
   localparam int HBD_B_FLAG_BIT     = 4;
   localparam int HBD_B_CFG_B_BIT    = 3;
   localparam int HBD_G_MUTE_BIT     = 7;
   // ------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------
   localparam logic [7:0] HBD_RST_DET_A  = 8'h00;
   localparam logic [7:0] HBD_RST_DET_B  = 8'h00;
   localparam logic [7:0] HBD_RST_GAIN_L = 8'h80;
   localparam logic [1:0] HBD_TYPE_NONE  = 2'h0;
   localparam logic [1:0] HBD_TYPE_NOMIC = 2'h1;
   localparam logic [1:0] HBD_TYPE_MIC   = 2'h3;
   localparam logic [6:0] HBD_GAIN_MAX   = 7'h77;
   // ------------------------------------------------------------
   // timing: base sample tick 1 ms, debounce windows are 8 ticks
   // ------------------------------------------------------------
   localparam int HBD_CLK_HZ       = 50_000_000;
   localparam int HBD_BASE_TICK_MS = 1;
   localparam int HBD_BASE_CYCLES  = HBD_CLK_HZ / 1000 * HBD_BASE_TICK_MS;
   localparam int HBD_DB_SAMPLES   = 8;
   localparam logic [2:0] HBD_JACK_SHIFT0 = 3'h1;
endpackage : hbd_pkg

// *** rtl/hbd_debounce.sv ***
module hbd_debounce
   import hbd_pkg::*;
#(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   // control
   input  wire logic         sample_en,
   input  wire logic         bypass,
   input  wire logic [W-1:0] raw,
   // result
   output logic      [W-1:0] stable
);
   logic [W-1:0] cand;
   logic [W-1:0] next_cand;
   logic [3:0]   cnt;
   logic [3:0]   next_cnt;
   logic [W-1:0] next_stable;

   // accept raw only after it held for the full sample window; with bypass set, raw passes to stable in the next cycle
   always_comb begin
      next_cand   = cand;
      next_cnt    = cnt;
      next_stable = stable;
      if (bypass) begin
         next_stable = raw;
         next_cand   = raw;
         next_cnt    = 4'h0;
      end else if (sample_en) begin
         if (raw != cand) begin
            next_cand = raw;
            next_cnt  = 4'h0;
         end else if (cnt == 4'(HBD_DB_SAMPLES - 1)) begin
            next_stable = cand;
         end else begin
            next_cnt = cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cand   <= '0;
         cnt    <= 4'h0;
         stable <= '0;
      end else begin
         cand   <= next_cand;
         cnt    <= next_cnt;
         stable <= next_stable;
      end
   end
endmodule : hbd_debounce

// *** rtl/hbd_regs.sv ***
// Overview of operation
// - detection runs only while the enable bit is one; reset zero
// - two-bit type: 00 none, 01 no microphone, 11 microphone
// - jack debounce code n gives 16 ms times two to the n for n up to 5; codes 6 and 7 give 512 ms like code 5
// - button debounce: none, 8 ms, 16 ms, 32 ms
// - coupling bit selects capacitor-free at zero, ac-coupled at one
// - configuration bit A selects fully differential outputs
// - configuration bit B selects pseudodifferential outputs
// - reserved bits of the second register read zero
// - read-only flag shows a detected headset
// - mute bit mutes the left amplifier; resets to muted
// - gain code steps by half a decibel from zero
// - codes 0x77 and above all give 59.5 dB
module hbd_regs
   import hbd_pkg::*;
#(
   parameter int BASE_CYCLES = HBD_BASE_CYCLES
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // jack pins
   input  wire logic       jack_present_pin,
   input  wire logic       jack_mic_pin,
   input  wire logic       button_pin,
   // outputs to analog
   output logic            det_enable,
   output logic            button_pressed,
   output logic            drv_ac_coupled,
   output logic            drv_fully_diff,
   output logic            drv_pseudo_diff,
   output logic            adc_l_mute,
   output logic      [6:0] adc_l_gain_code
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]  reg_a, next_reg_a;
   logic [7:0]  reg_b, next_reg_b;
   logic [7:0]  reg_g, next_reg_g;

   always_comb begin
      next_reg_a = reg_a;
      next_reg_b = reg_b;
      next_reg_g = reg_g;
      if (reg_wr) begin
         case (reg_addr)
            HBD_ADDR_DET_A:  next_reg_a = reg_wdata;
            HBD_ADDR_DET_B:  next_reg_b = reg_wdata;
            HBD_ADDR_GAIN_L: next_reg_g = reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reg_a <= HBD_RST_DET_A;
         reg_b <= HBD_RST_DET_B;
         reg_g <= HBD_RST_GAIN_L;
      end else begin
         reg_a <= next_reg_a;
         reg_b <= next_reg_b;
         reg_g <= next_reg_g;
      end
   end

   assign det_enable      = reg_a[HBD_A_EN_BIT];
   assign drv_ac_coupled  = reg_b[HBD_B_COUPLE_BIT];
   assign drv_fully_diff  = reg_b[HBD_B_CFG_A_BIT];
   assign drv_pseudo_diff = reg_b[HBD_B_CFG_B_BIT];
   assign adc_l_mute      = reg_g[HBD_G_MUTE_BIT];
   // gain code saturates; half-dB step means gain_db = code/2
   assign adc_l_gain_code = (reg_g[6:0] > HBD_GAIN_MAX) ? HBD_GAIN_MAX : reg_g[6:0];

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync1, sync2;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {button_pin, jack_mic_pin, jack_present_pin};
         sync2 <= sync1;
      end
   end

   // ------------------------------------------------------------
   // sample tick dividers: 1 ms base, then powers of two
   // ------------------------------------------------------------
   logic [31:0] base_cnt, next_base_cnt;
   logic        base_tick;
   logic [7:0]  ms_cnt, next_ms_cnt;
   logic [2:0]  jack_db;
   logic [1:0]  btn_db;
   logic        jack_tick, btn_tick;

   assign base_tick = (base_cnt == 32'(BASE_CYCLES - 1));
   assign jack_db   = reg_a[HBD_A_JACK_DB_LSB +: 3];
   assign btn_db    = reg_a[HBD_A_BTN_DB_LSB +: 2];

   always_comb begin
      next_base_cnt = base_tick ? 32'h0000_0000 : base_cnt + 32'h0000_0001;
      next_ms_cnt   = base_tick ? ms_cnt + 8'h01 : ms_cnt;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         base_cnt <= 32'h0000_0000;
         ms_cnt   <= 8'h00;
      end else begin
         base_cnt <= next_base_cnt;
         ms_cnt   <= next_ms_cnt;
      end
   end

   // jack tick every 2<<code ms; reserved codes clamp to the slowest
   logic [2:0] jack_sh;
   always_comb begin
      jack_sh   = (jack_db > 3'h5) ? 3'h6 : jack_db + HBD_JACK_SHIFT0;
      jack_tick = base_tick &&
                  ((ms_cnt & ((8'h01 << jack_sh) - 8'h01)) == 8'h00);
      btn_tick  = base_tick &&
                  ((ms_cnt & ((8'h01 << (btn_db - 2'h1)) - 8'h01)) == 8'h00);
   end

   // ------------------------------------------------------------
   // debouncers: 8 samples per window
   // ------------------------------------------------------------
   logic [1:0] jack_stable;
   logic [0:0] btn_stable;

   hbd_debounce #(.W(2)) u_jack (
      .core_clk  (core_clk),
      .reset_n   (reset_n && det_enable),
      .sample_en (jack_tick),
      .bypass    (1'b0),
      .raw       (sync2[1:0]),
      .stable    (jack_stable)
   );

   hbd_debounce #(.W(1)) u_btn (
      .core_clk  (core_clk),
      .reset_n   (reset_n && det_enable),
      .sample_en (btn_tick),
      .bypass    (btn_db == 2'h0),
      .raw       (sync2[2:2]),
      .stable    (btn_stable)
   );

   // ------------------------------------------------------------
   // detection result
   // ------------------------------------------------------------
   logic [1:0] det_type;
   logic       det_flag;
   always_comb begin
      det_type = HBD_TYPE_NONE;
      if (det_enable && jack_stable[0]) begin
         det_type = jack_stable[1] ? HBD_TYPE_MIC : HBD_TYPE_NOMIC;
      end
      det_flag = (det_type != HBD_TYPE_NONE);
   end

   assign button_pressed = det_enable && (det_type == HBD_TYPE_MIC) && btn_stable[0];

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [7:0] rd_b;
   always_comb begin
      rd_b = 8'h00;
      rd_b[HBD_B_COUPLE_BIT] = reg_b[HBD_B_COUPLE_BIT];
      rd_b[HBD_B_CFG_A_BIT]  = reg_b[HBD_B_CFG_A_BIT];
      rd_b[HBD_B_FLAG_BIT]   = det_flag;
      rd_b[HBD_B_CFG_B_BIT]  = reg_b[HBD_B_CFG_B_BIT];
      case (reg_addr)
         HBD_ADDR_DET_A:  reg_rdata = {reg_a[7], det_type, reg_a[4:0]};
         HBD_ADDR_DET_B:  reg_rdata = rd_b;
         HBD_ADDR_GAIN_L: reg_rdata = reg_g;
         default:         reg_rdata = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_disabled;
      !det_enable;
   endsequence

   a_disabled_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_disabled |-> (det_type == HBD_TYPE_NONE) && !det_flag)
      else $error("type or flag set while disabled");
   a_db_held: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_disabled |=> (jack_stable == 2'h0) && !btn_stable[0])
      else $error("debouncer state kept while disabled");
   a_type_legal: assert property (@(posedge core_clk) disable iff (!reset_n)
      det_type != 2'h2)
      else $error("reserved type code reported");
   a_flag_type: assert property (@(posedge core_clk) disable iff (!reset_n)
      det_flag == (det_type != HBD_TYPE_NONE))
      else $error("flag disagrees with type");
   a_gain_sat: assert property (@(posedge core_clk) disable iff (!reset_n)
      adc_l_gain_code <= HBD_GAIN_MAX)
      else $error("gain above maximum");
   a_gain_lin: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_g[6:0] <= HBD_GAIN_MAX) |-> adc_l_gain_code == reg_g[6:0])
      else $error("gain code not passed through");
   a_mute_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == HBD_ADDR_GAIN_L) |=> adc_l_mute == $past(reg_wdata[7]))
      else $error("mute did not follow write");
   a_b_reserved: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_addr == HBD_ADDR_DET_B) |-> (reg_rdata & 8'h27) == 8'h00)
      else $error("reserved bits read nonzero");
   a_en_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == HBD_ADDR_DET_A) |=> det_enable == $past(reg_wdata[7]))
      else $error("enable did not follow write");
   a_drv_cfg: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == HBD_ADDR_DET_B) |=>
         {drv_ac_coupled, drv_fully_diff, drv_pseudo_diff} ==
         {$past(reg_wdata[7]), $past(reg_wdata[6]), $past(reg_wdata[3])})
      else $error("driver config did not follow write");
endmodule : hbd_regs

// *** test/hbd_jack_model.sv ***
module hbd_jack_model (
   // clock
   input  wire logic core_clk,
   // accessory state
   input  wire logic plugged,
   input  wire logic mic_fitted,
   input  wire logic pressed,
   // jack contacts
   output logic      jack_present_pin,
   output logic      jack_mic_pin,
   output logic      button_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       was = 1'b0;
   logic [2:0] bounce = 3'h0;
   // contact chatter on insertion, shorter than any debounce tick
   always @(posedge core_clk) begin
      was <= plugged;
      if (plugged && !was) begin
         bounce <= 3'h5;
      end else if (bounce != 3'h0) begin
         bounce <= bounce - 3'h1;
      end
   end
   assign jack_present_pin = plugged & ~bounce[0];
   assign jack_mic_pin     = plugged & mic_fitted;
   assign button_pin       = plugged & mic_fitted & pressed;
endmodule : hbd_jack_model

// *** test/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import hbd_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int BC = 4;
   logic       core_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       plugged = 1'b0;
   logic       mic_fitted = 1'b0;
   logic       pressed = 1'b0;
   logic       jp, jm, bp, den, bpr, dac, dfd, dpd, mute;
   logic [6:0] gain;
   int         errors = 0;
   int         n_tests = 0;
   always #10 core_clk = ~core_clk;
   hbd_jack_model acc_u (.core_clk(core_clk), .plugged(plugged), .mic_fitted(mic_fitted),
      .pressed(pressed), .jack_present_pin(jp), .jack_mic_pin(jm), .button_pin(bp));
   hbd_regs #(.BASE_CYCLES(BC)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .jack_present_pin(jp), .jack_mic_pin(jm), .button_pin(bp), .det_enable(den),
      .button_pressed(bpr), .drv_ac_coupled(dac), .drv_fully_diff(dfd),
      .drv_pseudo_diff(dpd), .adc_l_mute(mute), .adc_l_gain_code(gain));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk_n(input int n, input int lo, input int hi);
      n_tests++;
      if (n < lo || n > hi) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
      end
   endtask : chk_n
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      @(negedge core_clk);
      v = reg_rdata;
   endtask : rd
   // which=0 polls the type field, which=1 the button output
   task wt(input bit which, input logic [7:0] exp, output int n);
      logic [7:0] v;
      n = 0;
      @(posedge core_clk);
      reg_addr <= HBD_ADDR_DET_A;
      do begin
         @(negedge core_clk);
         n++;
         v = which ? {7'h00, bpr} : {6'h00, reg_rdata[6:5]};
      end while (v !== exp && n < 4000);
      chk(v, exp);
   endtask : wt
   task give_verdict;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task s_reset;
      logic [7:0] v;
      rd(HBD_ADDR_DET_A, v); chk(v, 8'h00);
      rd(HBD_ADDR_DET_B, v); chk(v, 8'h00);
      rd(HBD_ADDR_GAIN_L, v); chk(v, 8'h80);
      rd(8'h10, v); chk(v, 8'h00);
      @(posedge core_clk); plugged <= 1'b1; mic_fitted <= 1'b1;
      repeat (200) @(posedge core_clk);
      rd(HBD_ADDR_DET_A, v); chk(v, 8'h00);
      rd(HBD_ADDR_DET_B, v); chk(v, 8'h00);
   endtask : s_reset
   task s_button;
      logic [7:0] v;
      int         n;
      wr(HBD_ADDR_DET_A, 8'hc1);
      wt(0, 8'h03, n);
      rd(HBD_ADDR_DET_A, v); chk(v, 8'he1);
      rd(HBD_ADDR_DET_B, v); chk(v, 8'h10);
      chk({7'h00, den}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wr(HBD_ADDR_DET_A, {6'h20, c[1:0]});
         @(posedge core_clk); pressed <= !c[0];
         wt(1, {7'h00, !c[0]}, n);
         if (c == 0) chk_n(n, 0, 6);
         else chk_n(n, 7 * (BC << (c - 1)), 9 * (BC << (c - 1)) + 8);
      end
   endtask : s_button
   task s_jack;
      int n;
      // codes 110 and 111 never written
      for (int c = 0; c < 6; c++) begin
         wr(HBD_ADDR_DET_A, {3'h4, c[2:0], 2'h0});
         @(posedge core_clk); plugged <= c[0];
         wt(0, c[0] ? 8'h03 : 8'h00, n);
         chk_n(n, 7 * (BC << (c + 1)), 9 * (BC << (c + 1)) + 8);
      end
   endtask : s_jack
   task s_nomic;
      logic [7:0] v;
      int         n;
      wr(HBD_ADDR_DET_A, 8'h80);
      @(posedge core_clk); plugged <= 1'b0;
      wt(0, 8'h00, n);
      @(posedge core_clk); mic_fitted <= 1'b0; plugged <= 1'b1;
      wt(0, 8'h01, n);
      wr(HBD_ADDR_DET_A, 8'h00);
      rd(HBD_ADDR_DET_A, v); chk(v, 8'h00);
      rd(HBD_ADDR_DET_B, v); chk(v, 8'h00);
      chk({7'h00, den}, 8'h00);
   endtask : s_nomic
   task s_regb;
      logic [7:0] v;
      // bits 6 and 3 never written high together
      wr(HBD_ADDR_DET_B, 8'hc0);
      rd(HBD_ADDR_DET_B, v); chk(v, 8'hc0);
      chk({5'h00, dac, dfd, dpd}, 8'h06);
      wr(HBD_ADDR_DET_B, 8'hbf);
      rd(HBD_ADDR_DET_B, v); chk(v, 8'h88);
      chk({5'h00, dac, dfd, dpd}, 8'h05);
   endtask : s_regb
   task s_gain;
      logic [7:0] d[5];
      logic [6:0] g[5];
      logic [7:0] v;
      d = '{8'h10, 8'h76, 8'h77, 8'h7f, 8'hff};
      g = '{7'h10, 7'h76, 7'h77, 7'h77, 7'h77};
      for (int i = 0; i < 5; i++) begin
         wr(HBD_ADDR_GAIN_L, d[i]);
         @(negedge core_clk);
         chk({mute, gain}, {d[i][7], g[i]});
      end
      wr(HBD_ADDR_GAIN_L, 8'h10);
      rd(HBD_ADDR_GAIN_L, v); chk(v, 8'h10);
   endtask : s_gain
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      s_reset;
      s_button;
      s_jack;
      s_nomic;
      s_regb;
      s_gain;
      give_verdict();
   end
   // the whole sequence needs about 5000 cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      errors++;
      give_verdict();
   end
endmodule : testbench
